// >>> verilog/rdbs_pkg.sv
package rdbs_pkg;

  localparam logic [7:0] RDBS_OFS_MODEM_CTRL = 8'h00;
  localparam logic [7:0] RDBS_OFS_EXTRA_CTRL = 8'h04;
  localparam logic [7:0] RDBS_OFS_ENH_FEAT = 8'h08;
  localparam logic [7:0] RDBS_OFS_DIV_LOW = 8'h0C;
  localparam logic [7:0] RDBS_OFS_DIV_HIGH = 8'h10;
  localparam logic [7:0] RDBS_OFS_SAMPLE_ADJ = 8'h14;
  localparam logic [7:0] RDBS_OFS_FRAC_ADJ = 8'h18;
  localparam logic [7:0] RDBS_OFS_INT_STATUS = 8'h1C;
  localparam logic [7:0] RDBS_OFS_INT_MASK = 8'h20;
  localparam logic [7:0] RDBS_OFS_LINE_STATE = 8'h24;

  localparam int RDBS_MODEM_RTS_BIT = 1;
  localparam int RDBS_MODEM_PRESCALE_BIT = 7;
  localparam int RDBS_EXTRA_MULTIDROP_BIT = 0;
  localparam int RDBS_EXTRA_AUTO_DIR_BIT = 4;
  localparam int RDBS_EXTRA_INVERT_BIT = 5;
  localparam int RDBS_ENH_HW_FLOW_BIT = 6;

  localparam int RDBS_INT_ADDR_BIT = 0;
  localparam int RDBS_INT_TXDONE_BIT = 1;
  localparam int RDBS_INT_WIDTH = 2;

  localparam logic [7:0] RDBS_REG_RESET = 8'h00;
  localparam logic [7:0] RDBS_SAMPLE_BASE = 8'h10;
  localparam logic [1:0] RDBS_PRESCALE_LAST = 2'h3;
  localparam logic [1:0] RDBS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RDBS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] modem_ctrl;
    logic [7:0] extra_ctrl;
    logic [7:0] enh_feat;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] sra;
    logic [7:0] fsa;
    logic [RDBS_INT_WIDTH-1:0] ist;
    logic [RDBS_INT_WIDTH-1:0] imask;
    logic busy;
    logic rts_n;
    logic [1:0] pre;
    logic [15:0] dcnt;
    logic [7:0] scnt;
    logic tick16;
    logic tickbit;
    logic addr_pulse;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rdbs_state_t;

endpackage

// >>> verilog/rdbs_top.sv
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
// Summary of operation
// - Otherwise modem control bit 1 drives RTS.
// - Flow control drives RTS when auto-direction off.
// - Auto-direction bit 4 overrides other RTS sources.
// - Auto mode: FIFO write drives RTS low.
// - Auto mode: RTS high after last bit.
// - Bit 5 inverts RTS in auto mode.
// - Bit 0 selects multidrop 9-bit receive.
// - Parity-one character is address, raises interrupt.
// - Prescale, 16-bit divisor, then sample rate.
// - Zero divisor gives no baud clock.
module rdbs_top
  import rdbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic tx_fifo_wr_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_shift_empty_i,
  input wire logic flow_rts_n_i,
  input wire logic rx_char_valid_i,
  input wire logic rx_parity_i,
  output logic rts_n_o,
  output logic baud16_tick_o,
  output logic baud_bit_tick_o,
  output logic addr_char_o,
  output logic irq_o
);

  rdbs_state_t s_ff;
  rdbs_state_t nxt_s;
  logic wr_go;
  logic rd_go;
  logic [15:0] divisor;
  logic [7:0] sample_rate;
  logic tx_idle;

  assign divisor = {s_ff.div_high, s_ff.div_low};
  assign sample_rate = RDBS_SAMPLE_BASE - s_ff.sra + s_ff.fsa;
  assign tx_idle = tx_fifo_empty_i && tx_shift_empty_i;

  // Both write channels are taken in one edge, so a lone address waits.
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_ff.bvalid;
  assign rd_go = s_axi_arvalid_i && !s_ff.rvalid;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_arready_o = rd_go;
  assign s_axi_bvalid_o = s_ff.bvalid;
  assign s_axi_bresp_o = s_ff.bresp;
  assign s_axi_rvalid_o = s_ff.rvalid;
  assign s_axi_rdata_o = s_ff.rdata;
  assign s_axi_rresp_o = s_ff.rresp;
  assign rts_n_o = s_ff.rts_n;
  assign baud16_tick_o = s_ff.tick16;
  assign baud_bit_tick_o = s_ff.tickbit;
  assign addr_char_o = s_ff.addr_pulse;
  assign irq_o = |(s_ff.ist & s_ff.imask);

  always_comb begin
    logic pre_en;
    logic tx_done;
    logic rd_ist;
    logic [RDBS_INT_WIDTH-1:0] ev;
    pre_en = 1'b0;
    tx_done = 1'b0;
    rd_ist = 1'b0;
    ev = '0;
    nxt_s = s_ff;
    nxt_s.tick16 = 1'b0;
    nxt_s.tickbit = 1'b0;
    nxt_s.addr_pulse = 1'b0;

    // The divisor counter is held at zero while both bytes are zero.
    pre_en = !s_ff.modem_ctrl[RDBS_MODEM_PRESCALE_BIT] ||
             (s_ff.pre == RDBS_PRESCALE_LAST);
    if (divisor == 16'h0000) begin
      nxt_s.pre = 2'h0;
      nxt_s.dcnt = 16'h0000;
      nxt_s.scnt = 8'h00;
    end else begin
      nxt_s.pre = s_ff.pre + 2'h1;
      if (pre_en) begin
        if (s_ff.dcnt >= divisor - 16'h0001) begin
          nxt_s.dcnt = 16'h0000;
          nxt_s.tick16 = 1'b1;
          if (s_ff.scnt >= sample_rate - 8'h01) begin
            nxt_s.scnt = 8'h00;
            nxt_s.tickbit = 1'b1;
          end else begin
            nxt_s.scnt = s_ff.scnt + 8'h01;
          end
        end else begin
          nxt_s.dcnt = s_ff.dcnt + 16'h0001;
        end
      end
    end

    // A write in the same cycle as the drain keeps the line turned round.
    if (!s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT]) begin
      nxt_s.busy = 1'b0;
    end else if (tx_fifo_wr_i) begin
      nxt_s.busy = 1'b1;
    end else if (tx_idle) begin
      nxt_s.busy = 1'b0;
    end
    tx_done = s_ff.busy && !nxt_s.busy;

    if (s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT]) begin
      nxt_s.rts_n = !nxt_s.busy ^
                    s_ff.extra_ctrl[RDBS_EXTRA_INVERT_BIT];
    end else if (s_ff.enh_feat[RDBS_ENH_HW_FLOW_BIT]) begin
      nxt_s.rts_n = flow_rts_n_i;
    end else begin
      nxt_s.rts_n = !s_ff.modem_ctrl[RDBS_MODEM_RTS_BIT];
    end

    if (s_ff.extra_ctrl[RDBS_EXTRA_MULTIDROP_BIT] && rx_char_valid_i &&
        rx_parity_i) begin
      nxt_s.addr_pulse = 1'b1;
    end
    ev[RDBS_INT_ADDR_BIT] = nxt_s.addr_pulse;
    ev[RDBS_INT_TXDONE_BIT] = tx_done;

    if (s_ff.bvalid && s_axi_bready_i) begin
      nxt_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RDBS_RESP_OKAY;
      if (s_axi_wstrb_i[0]) begin
        case (s_axi_awaddr_i[7:0])
          RDBS_OFS_MODEM_CTRL: nxt_s.modem_ctrl = s_axi_wdata_i[7:0];
          RDBS_OFS_EXTRA_CTRL: nxt_s.extra_ctrl = s_axi_wdata_i[7:0];
          RDBS_OFS_ENH_FEAT: nxt_s.enh_feat = s_axi_wdata_i[7:0];
          RDBS_OFS_DIV_LOW: nxt_s.div_low = s_axi_wdata_i[7:0];
          RDBS_OFS_DIV_HIGH: nxt_s.div_high = s_axi_wdata_i[7:0];
          RDBS_OFS_SAMPLE_ADJ: nxt_s.sra = s_axi_wdata_i[7:0];
          RDBS_OFS_FRAC_ADJ: nxt_s.fsa = s_axi_wdata_i[7:0];
          RDBS_OFS_INT_MASK:
            nxt_s.imask = s_axi_wdata_i[RDBS_INT_WIDTH-1:0];
          RDBS_OFS_INT_STATUS, RDBS_OFS_LINE_STATE: ;
          default: nxt_s.bresp = RDBS_RESP_SLVERR;
        endcase
      end
      if (s_axi_awaddr_i[31:8] != 24'h000000) begin
        nxt_s.bresp = RDBS_RESP_SLVERR;
      end
    end

    if (s_ff.rvalid && s_axi_rready_i) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RDBS_RESP_OKAY;
      nxt_s.rdata = 32'h00000000;
      case (s_axi_araddr_i[7:0])
        RDBS_OFS_MODEM_CTRL: nxt_s.rdata[7:0] = s_ff.modem_ctrl;
        RDBS_OFS_EXTRA_CTRL: nxt_s.rdata[7:0] = s_ff.extra_ctrl;
        RDBS_OFS_ENH_FEAT: nxt_s.rdata[7:0] = s_ff.enh_feat;
        RDBS_OFS_DIV_LOW: nxt_s.rdata[7:0] = s_ff.div_low;
        RDBS_OFS_DIV_HIGH: nxt_s.rdata[7:0] = s_ff.div_high;
        RDBS_OFS_SAMPLE_ADJ: nxt_s.rdata[7:0] = s_ff.sra;
        RDBS_OFS_FRAC_ADJ: nxt_s.rdata[7:0] = s_ff.fsa;
        RDBS_OFS_INT_STATUS: begin
          nxt_s.rdata[RDBS_INT_WIDTH-1:0] = s_ff.ist;
          rd_ist = 1'b1;
        end
        RDBS_OFS_INT_MASK:
          nxt_s.rdata[RDBS_INT_WIDTH-1:0] = s_ff.imask;
        RDBS_OFS_LINE_STATE:
          nxt_s.rdata[2:0] = {divisor != 16'h0000, s_ff.rts_n, s_ff.busy};
        default: nxt_s.rresp = RDBS_RESP_SLVERR;
      endcase
      if (s_axi_araddr_i[31:8] != 24'h000000) begin
        nxt_s.rresp = RDBS_RESP_SLVERR;
        nxt_s.rdata = 32'h00000000;
        rd_ist = 1'b0;
      end
    end

    // The clear by read comes first, so an event in that cycle survives.
    nxt_s.ist = (rd_ist ? '0 : s_ff.ist) | ev;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_ff <= '0;
      s_ff.rts_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  a_rts_manual: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (!s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT] &&
     !s_ff.enh_feat[RDBS_ENH_HW_FLOW_BIT])
    |=> (rts_n_o == !$past(s_ff.modem_ctrl[RDBS_MODEM_RTS_BIT])))
    else $error("RTS does not follow the modem control bit.");

  a_rts_flow: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (!s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT] &&
     s_ff.enh_feat[RDBS_ENH_HW_FLOW_BIT])
    |=> (rts_n_o == $past(flow_rts_n_i)))
    else $error("RTS does not follow flow control.");

  a_auto_assert: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT] &&
     !s_ff.extra_ctrl[RDBS_EXTRA_INVERT_BIT] && tx_fifo_wr_i) |=> !rts_n_o)
    else $error("RTS not driven low after FIFO write.");

  a_auto_invert: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT] &&
     s_ff.extra_ctrl[RDBS_EXTRA_INVERT_BIT] && tx_fifo_wr_i) |=> rts_n_o)
    else $error("Inverted RTS not high after FIFO write.");

  a_auto_release: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT] &&
     !s_ff.extra_ctrl[RDBS_EXTRA_INVERT_BIT] &&
     s_ff.busy && tx_idle && !tx_fifo_wr_i) |=> rts_n_o)
    else $error("RTS not released after the last bit.");

  a_auto_hold: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (s_ff.extra_ctrl[RDBS_EXTRA_AUTO_DIR_BIT] && s_ff.busy && !tx_idle
     && !wr_go) |=> (s_ff.busy && $stable(rts_n_o)))
    else $error("RTS dropped before the transmitter drained.");

  a_zero_divisor: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (divisor == 16'h0000) |=> (!baud16_tick_o && !baud_bit_tick_o))
    else $error("Baud tick with zero divisor.");

  a_div_one: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (divisor == 16'h0001 && !s_ff.modem_ctrl[RDBS_MODEM_PRESCALE_BIT])
    |=> baud16_tick_o)
    else $error("Divisor one without prescale missed a tick.");

  a_addr_detect: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    (s_ff.extra_ctrl[RDBS_EXTRA_MULTIDROP_BIT] && rx_char_valid_i &&
     rx_parity_i) |=> (addr_char_o && s_ff.ist[RDBS_INT_ADDR_BIT]))
    else $error("Address character not flagged.");

  a_addr_off: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    !s_ff.extra_ctrl[RDBS_EXTRA_MULTIDROP_BIT] |=> !addr_char_o)
    else $error("Address flag outside multidrop mode.");

endmodule

// >>> bench/rdbs_tx_model.sv
`timescale 1ns/100ps
// Transmit FIFO and shifter stand-in. The FIFO empties before the shifter,
// so the design must wait for both flags and not only the first.
module rdbs_tx_model #(
  parameter int LEN = 20
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wr_i,
  output logic fifo_empty_o,
  output logic shift_empty_o
);
  int cnt;
  always @(posedge clk_i) begin
    if (!rst_b_i) cnt <= 0;
    else if (wr_i) cnt <= LEN;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign fifo_empty_o = cnt < LEN / 2;
  assign shift_empty_o = cnt == 0;
endmodule

// >>> bench/rdbs_top_tb_top.sv
`timescale 1ns/100ps
module rdbs_top_tb_top
  import rdbs_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic wr = 1'h0, flow = 1'h1, rxv = 1'h0, rxp = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, fe, se;
  logic rts, b16, bb, addr, irq, got;
  logic [31:0] rdata, d;
  logic [1:0] bresp, rresp, r;
  int bad_count = 0, total_checks = 0, g;
  always #12.5 clk_i = ~clk_i;
  rdbs_top rdbs_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .tx_fifo_wr_i(wr), .tx_fifo_empty_i(fe), .tx_shift_empty_i(se),
    .flow_rts_n_i(flow), .rx_char_valid_i(rxv), .rx_parity_i(rxp),
    .rts_n_o(rts), .baud16_tick_o(b16), .baud_bit_tick_o(bb),
    .addr_char_o(addr), .irq_o(irq));
  rdbs_tx_model rdbs_tx_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .wr_i(wr), .fifo_empty_o(fe), .shift_empty_o(se));
  task stop_test();
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    total_checks++;
    if (v !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask
  task bound(input int n);
    if (n >= 4000) begin
      chk("wait_bound", 32'h0, 32'h1);
      stop_test();
    end
  endtask
  // Ends at a falling edge, so outputs sampled after it are settled.
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Ready and valid are looked at on the falling edge, where they are
  // settled; the handshake itself completes at the next rising edge.
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, v};
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk_i);
      n++;
    end while (awready !== 1'h1 && n < 4000);
    @(posedge clk_i);
    awv <= 1'h0;
    wv <= 1'h0;
    do begin
      @(negedge clk_i);
      n++;
    end while (bvalid !== 1'h1 && n < 4000);
    r = bresp;
    @(posedge clk_i);
    bready <= 1'h0;
    bound(n);
  endtask
  task rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= {24'h0, a};
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk_i);
      n++;
    end while (arready !== 1'h1 && n < 4000);
    @(posedge clk_i);
    arv <= 1'h0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rvalid !== 1'h1 && n < 4000);
    d = rdata;
    r = rresp;
    @(posedge clk_i);
    rready <= 1'h0;
    bound(n);
  endtask
  // The first interval after a divisor change may be short; use the second.
  task gap(input logic s);
    int n;
    n = 0;
    repeat (2) begin
      g = 0;
      do begin
        @(negedge clk_i);
        g++;
      end while ((s ? bb : b16) !== 1'h1 && g < 4000);
      n = g;
    end
    bound(n);
  endtask
  task rx_char(input logic p);
    @(posedge clk_i);
    rxv <= 1'h1;
    rxp <= p;
    @(posedge clk_i);
    rxv <= 1'h0;
    @(negedge clk_i);
    got = addr;
  endtask
  task pulse_wr();
    @(posedge clk_i);
    wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
  endtask
  task t_reset();
    g = 0;
    repeat (64) begin
      @(negedge clk_i);
      if (b16 !== 1'h0) g++;
    end
    chk("tick_idle", 32'h0, g);
    rd_reg(RDBS_OFS_LINE_STATE);
    chk("line_state", 32'h2, d);
    rd_reg(8'h30);
    chk("unmapped", {30'h0, RDBS_RESP_SLVERR}, {30'h0, r});
    wr_reg(8'h30, 8'h00);
    chk("unmapped_wr", {30'h0, RDBS_RESP_SLVERR}, {30'h0, r});
  endtask
  task t_baud();
    wr_reg(RDBS_OFS_DIV_LOW, 8'h03);
    gap(1'h0);
    chk("tick16_gap", 32'h3, g);
    gap(1'h1);
    chk("bit_gap", 32'h30, g);
    wr_reg(RDBS_OFS_MODEM_CTRL, 8'h80);
    gap(1'h0);
    chk("prescale_gap", 32'hC, g);
    wr_reg(RDBS_OFS_MODEM_CTRL, 8'h00);
    wr_reg(RDBS_OFS_DIV_LOW, 8'h5A);
    wr_reg(RDBS_OFS_SAMPLE_ADJ, 8'hFD);
    gap(1'h1);
    chk("bit_gap_1800", 32'h6AE, g);
    wr_reg(RDBS_OFS_DIV_LOW, 8'h01);
    wr_reg(RDBS_OFS_SAMPLE_ADJ, 8'h00);
    gap(1'h1);
    chk("bit_gap_921600", 32'h10, g);
    wr_reg(RDBS_OFS_DIV_LOW, 8'h08);
    wr_reg(RDBS_OFS_FRAC_ADJ, 8'h0A);
    gap(1'h1);
    chk("bit_gap_115200", 32'hD0, g);
    wr_reg(RDBS_OFS_FRAC_ADJ, 8'h00);
  endtask
  task t_sources();
    wr_reg(RDBS_OFS_MODEM_CTRL, 8'h02);
    cyc(2);
    chk("rts_mcr", 32'h0, rts);
    wr_reg(RDBS_OFS_ENH_FEAT, 8'h40);
    cyc(2);
    chk("rts_flow_hi", 32'h1, rts);
    @(posedge clk_i);
    flow <= 1'h0;
    cyc(2);
    chk("rts_flow_lo", 32'h0, rts);
    wr_reg(RDBS_OFS_ENH_FEAT, 8'h00);
    wr_reg(RDBS_OFS_EXTRA_CTRL, 8'h10);
    cyc(2);
    chk("rts_auto_idle", 32'h1, rts);
    pulse_wr();
    cyc(2);
    chk("rts_auto_on", 32'h0, rts);
    cyc(5);
    pulse_wr();
    cyc(14);
    chk("rts_auto_hold", 32'h0, rts);
    cyc(12);
    chk("rts_auto_off", 32'h1, rts);
    wr_reg(RDBS_OFS_EXTRA_CTRL, 8'h30);
    cyc(2);
    chk("rts_inv_idle", 32'h0, rts);
    pulse_wr();
    cyc(2);
    chk("rts_inv_on", 32'h1, rts);
    cyc(30);
    chk("rts_inv_off", 32'h0, rts);
  endtask
  task t_multidrop();
    wr_reg(RDBS_OFS_EXTRA_CTRL, 8'h01);
    rd_reg(RDBS_OFS_INT_STATUS);
    rx_char(1'h1);
    chk("addr_char", 32'h1, got);
    chk("irq_masked", 32'h0, irq);
    wr_reg(RDBS_OFS_INT_MASK, 8'h01);
    cyc(0);
    chk("irq_on", 32'h1, irq);
    rd_reg(RDBS_OFS_INT_STATUS);
    chk("status", 32'h1, d);
    cyc(0);
    chk("irq_clear", 32'h0, irq);
    rx_char(1'h0);
    chk("data_char", 32'h0, got);
    wr_reg(RDBS_OFS_EXTRA_CTRL, 8'h00);
    rx_char(1'h1);
    chk("mode_off", 32'h0, got);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'h1;
    t_reset();
    t_baud();
    t_sources();
    t_multidrop();
    stop_test();
  end
endmodule
